// ---- bench/dcsw_chk_asserts.sv ----
/*
 * Port checks of the serial command decoder.
 * Assumes binding into dcsw_top, one reference clock domain.
 */
`timescale 1ns/1ps

module dcsw_chk #(
    parameter int NUM_CH   = 4,
    parameter int TICK_CYC = 40000
) (
    // Clock, reset and frame pin
    input  wire logic                         ref_clk_in,
    input  wire logic                         rst_in,
    input  wire logic                         frame_n_in,
    // Watched outputs
    input  dcsw_pkg::dcsw_chan_t [NUM_CH-1:0] chan_cfg_out,
    input  wire logic [NUM_CH-1:0]            span_ext_out,
    input  wire logic [NUM_CH-1:0]            is_current_out,
    input  dcsw_pkg::dcsw_dcdc_t              dcdc_cfg_out,
    input  wire logic                         user_toggle_out,
    input  wire logic                         wd_en_out,
    input  wire logic                         alert_out,
    input  wire logic                         alert_oe_n_out
);
    import dcsw_pkg::*;

    logic [NUM_CH-1:0] span_exp;
    logic [NUM_CH-1:0] cur_exp;
    logic [NUM_CH-1:0] boost_v;
    logic [NUM_CH-1:0] en_v;

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            span_exp[i] = chan_cfg_out[i].overrange_en & ~chan_cfg_out[i].range_sel[2];
            cur_exp[i]  = chan_cfg_out[i].range_sel[2];
            boost_v[i]  = chan_cfg_out[i].boost_power;
            en_v[i]     = chan_cfg_out[i].out_en | chan_cfg_out[i].int_en;
        end
    end

    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // Margin of one cycle over the enable to fault to pin path
    sequence wd_idle;
        !wd_en_out [*4];
    endsequence

    sequence in_frame;
        !frame_n_in [*8];
    endsequence

    a_alert_data_low: assert property (alert_out == 1'b0)
        else $error("alert data not low");
    a_span_follow: assert property (span_ext_out == $past(span_exp))
        else $error("span flag wrong");
    a_current_flag: assert property (is_current_out == $past(cur_exp))
        else $error("current flag wrong");
    a_wd_off_quiet: assert property (wd_idle |-> alert_oe_n_out)
        else $error("alert with watchdog off");
    a_alert_needs_wd: assert property ($fell(alert_oe_n_out) |-> wd_en_out)
        else $error("alert without watchdog");
    a_boost_down_gated: assert property (
        |($past(boost_v) & ~boost_v) |-> (($past(boost_v) & ~boost_v & en_v) == '0))
        else $error("boost off with enables set");
    a_reset_values: assert property ($past(rst_in) |-> dcdc_cfg_out == 7'h04 &&
        alert_oe_n_out && !wd_en_out && !user_toggle_out)
        else $error("bad reset values");
    a_cfg_hold_frame: assert property (in_frame |-> $stable(chan_cfg_out) &&
        $stable(dcdc_cfg_out) && $stable(user_toggle_out))
        else $error("config moved inside frame");
endmodule : dcsw_chk

bind dcsw_top dcsw_chk #(.NUM_CH(NUM_CH), .TICK_CYC(TICK_CYC)) u_chk (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .frame_n_in(frame_n_in),
    .chan_cfg_out(chan_cfg_out), .span_ext_out(span_ext_out),
    .is_current_out(is_current_out), .dcdc_cfg_out(dcdc_cfg_out),
    .user_toggle_out(user_toggle_out), .wd_en_out(wd_en_out),
    .alert_out(alert_out), .alert_oe_n_out(alert_oe_n_out)
);

// ---- bench/dcsw_host.sv ----
/*
 * Host side of the 3-wire link: sends 16-bit frames, MSB first.
 * Assumes a free-running reference clock; each phase lasts 3 cycles.
 */
`timescale 1ns/1ps

module dcsw_host (
    // Clock
    input  wire logic ref_clk_in,
    // Serial link pins
    output logic      serial_clk_out,
    output logic      frame_n_out,
    output logic      serial_out
);
    initial begin
        serial_clk_out = 1'b0;
        frame_n_out    = 1'b1;
        serial_out     = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : wait_cyc

    // Clock idles low; data shows the inverse of its last bit
    task automatic send(input logic [15:0] word);
        wait_cyc(1);
        frame_n_out = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            wait_cyc(3);
            serial_out = word[i];
            wait_cyc(3);
            serial_clk_out = 1'b1;
            wait_cyc(3);
            serial_clk_out = 1'b0;
        end
        wait_cyc(3);
        frame_n_out = 1'b1;
        serial_out  = ~word[0];
        wait_cyc(8);
    endtask : send
endmodule : dcsw_host

// ---- bench/tb_top.sv ----
/*
 * Testbench of the serial command decoder.
 * Assumes dcsw_host for frames and a shortened watchdog tick.
 */
`timescale 1ns/1ps
`include "dcsw_params.svh"

module tb_top;
    import dcsw_pkg::*;
    localparam int NUM_CH   = 4;
    localparam int TICK_CYC = 4;

    logic                    ref_clk_in;
    logic                    rst_in;
    logic                    sclk;
    logic                    frame_n;
    logic                    sdata;
    dcsw_chan_t [NUM_CH-1:0] chan_cfg;
    logic [NUM_CH-1:0]       span_ext;
    logic [NUM_CH-1:0]       is_cur;
    dcsw_dcdc_t              dcdc_cfg;
    logic                    user_toggle;
    logic                    wd_en;
    logic [1:0]              wd_sel;
    logic                    alert;
    logic                    alert_oe_n;
    int                      err_count;
    int                      n_tests;

    dcsw_top #(.NUM_CH(NUM_CH), .TICK_CYC(TICK_CYC)) DUT (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .serial_clk_in(sclk),
        .frame_n_in(frame_n), .serial_in(sdata), .chan_cfg_out(chan_cfg),
        .span_ext_out(span_ext), .is_current_out(is_cur), .dcdc_cfg_out(dcdc_cfg),
        .user_toggle_out(user_toggle), .wd_en_out(wd_en), .wd_sel_out(wd_sel),
        .alert_out(alert), .alert_oe_n_out(alert_oe_n)
    );

    dcsw_host u_host (
        .ref_clk_in(ref_clk_in), .serial_clk_out(sclk), .frame_n_out(frame_n),
        .serial_out(sdata)
    );

    initial begin
        ref_clk_in = 1'b0;
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end

    ////////////////////////////////////////////////////////////
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [2:0] sel, input logic [12:0] body);
        u_host.send({sel, body});
    endtask : wr

    task automatic ticks(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : ticks

    function automatic logic [12:0] ch_word(input logic [1:0] ch, input logic [8:0] f);
        return {ch, 2'h0, f};
    endfunction : ch_word

    task automatic finish_test();
        $display("TB: checks=%0d errors=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////
    initial begin
        rst_in    = 1'b1;
        err_count = 0;
        n_tests   = 0;
        ticks(2);
        rst_in = 1'b0;
        ticks(3);
        check(chan_cfg, '0);
        check(dcdc_cfg, {1'b0, `DCSW_RST_DC_PHASE, `DCSW_RST_DC_FREQ, `DCSW_RST_DC_MAXV});
        check({user_toggle, wd_en, alert_oe_n}, 3'h1);
        // Every valid range code (0 to 5), overrange set
        for (int r = 0; r < 6; r++) begin
            wr(`DCSW_SEL_CHAN, ch_word(2'h1, {6'h01, r[2:0]}));
            check(chan_cfg[1].range_sel, r[2:0]);
            check(span_ext[1], r < 4);
            check(is_cur[1], r > 3);
        end
        wr(`DCSW_SEL_CHAN, ch_word(2'h1, 9'h003));
        check(span_ext[1], 1'b0);
        // Unused range code leaves the range alone
        wr(`DCSW_SEL_CHAN, ch_word(2'h1, 9'h00e));
        check(chan_cfg[1], 9'h00b);
        // Power-down only with both enables cleared
        wr(`DCSW_SEL_CHAN, ch_word(2'h2, 9'h1f0));
        check(chan_cfg[2], 9'h1f0);
        wr(`DCSW_SEL_CHAN, ch_word(2'h2, 9'h140));
        check(chan_cfg[2], 9'h150);
        wr(`DCSW_SEL_CHAN, ch_word(2'h2, 9'h000));
        check(chan_cfg[2], 9'h000);
        wr(`DCSW_SEL_MAIN, 13'h0001);
        for (int c = 0; c < NUM_CH; c++) begin
            check(chan_cfg[c].boost_power, 1'b1);
        end
        wr(`DCSW_SEL_DCDC, 13'h007b);
        check(dcdc_cfg, 7'h7b);
        // Link check through the status toggle
        wr(`DCSW_SEL_SW, 13'h1000);
        check(user_toggle, 1'b1);
        wr(`DCSW_SEL_SW, 13'h0000);
        check(user_toggle, 1'b0);
        // Watchdog at 400 cycles; three kicks outlast one timeout
        wr(`DCSW_SEL_MAIN, 13'h000a);
        check({wd_en, wd_sel}, 3'h6);
        repeat (3) wr(`DCSW_SEL_SW, {1'b0, `DCSW_CODE_KICK});
        check(alert_oe_n, 1'b1);
        wr(`DCSW_SEL_SW, 13'h0000);
        ticks(220);
        check(alert_oe_n, 1'b1);
        ticks(40);
        check({alert, alert_oe_n}, 2'h0);
        wr(`DCSW_SEL_SW, {1'b0, `DCSW_CODE_KICK});
        check(alert_oe_n, 1'b1);
        wr(`DCSW_SEL_MAIN, 13'h0000);
        ticks(600);
        check(alert_oe_n, 1'b1);
        // Soft reset with a live fault and toggle set
        wr(`DCSW_SEL_SW, 13'h1000);
        wr(`DCSW_SEL_MAIN, 13'h0002);
        ticks(40);
        check(alert_oe_n, 1'b0);
        wr(`DCSW_SEL_SW, {1'b1, `DCSW_CODE_RESET});
        check(chan_cfg, '0);
        check(dcdc_cfg, 7'h04);
        check({user_toggle, wd_en, alert_oe_n}, 3'h1);
        finish_test();
    end

    // Whole run is near 4800 cycles
    initial begin
        repeat (30000) @(posedge ref_clk_in);
        err_count++;
        finish_test();
    end
endmodule : tb_top

// ---- inc/dcsw_params.svh ----
/*
 * Constants of the channel control / software command decoder:
 * frame selects, field positions, reset values and timing counts.
 * Assumes a 40 MHz reference clock and 16-bit serial frames.
 */
`ifndef DCSW_PARAMS_SVH
`define DCSW_PARAMS_SVH

// Frame layout
`define DCSW_FRAME_BITS       16
`define DCSW_SEL_HI           15
`define DCSW_SEL_LO           13
`define DCSW_CODE_HI          11
`define DCSW_CODE_LO          0
`define DCSW_USER_BIT         12
`define DCSW_CH_HI            12
`define DCSW_CH_LO            11

// Frame selects (bits 15..13)
`define DCSW_SEL_MAIN         3'h1
`define DCSW_SEL_CHAN         3'h2
`define DCSW_SEL_DCDC         3'h3
`define DCSW_SEL_SW           3'h4

// Software command codes
`define DCSW_CODE_RESET       12'h555
`define DCSW_CODE_KICK        12'h195

// Main control fields
`define DCSW_MAIN_BOOST_ALL   0
`define DCSW_MAIN_WD_EN       1
`define DCSW_MAIN_WD_SEL_LO   2

// Channel control fields
`define DCSW_CH_INT_EN        8
`define DCSW_CH_CLR_EN        7
`define DCSW_CH_OUT_EN        6
`define DCSW_CH_RSET          5
`define DCSW_CH_BOOST         4
`define DCSW_CH_OVERRANGE_EN         3
`define DCSW_CH_RANGE_LO      0

// Boost converter control fields
`define DCSW_DC_COMP          6
`define DCSW_DC_PHASE_LO      4
`define DCSW_DC_FREQ_LO       2
`define DCSW_DC_MAXV_LO       0

// Reset values
`define DCSW_RST_RANGE        3'h0
`define DCSW_RST_DC_FREQ      2'h1
`define DCSW_RST_DC_PHASE     2'h0
`define DCSW_RST_DC_MAXV      2'h0

// Timing
`define DCSW_CLK_MHZ          40
`define DCSW_WD_TICK_US       1000
`define DCSW_WD_TICK_CYC      (`DCSW_WD_TICK_US * `DCSW_CLK_MHZ)
`define DCSW_WD_MS_0          16'h0005
`define DCSW_WD_MS_1          16'h000a
`define DCSW_WD_MS_2          16'h0064
`define DCSW_WD_MS_3          16'h00c8

`endif

// ---- inc/dcsw_pkg.sv ----
/*
 * Types of the channel control / software command decoder.
 * Constants live in dcsw_params.svh.
 */
package dcsw_pkg;

    typedef enum logic [2:0] {
        DCSW_RANGE_0_5V   = 3'h0,
        DCSW_RANGE_0_10V  = 3'h1,
        DCSW_RANGE_PM5V   = 3'h2,
        DCSW_RANGE_PM10V  = 3'h3,
        DCSW_RANGE_4_20MA = 3'h4,
        DCSW_RANGE_0_20MA = 3'h5
    } dcsw_range_t;

    typedef enum logic [1:0] {
        DCSW_RX_IDLE  = 2'h0,
        DCSW_RX_SHIFT = 2'h1,
        DCSW_RX_DONE  = 2'h3
    } dcsw_rx_t;

    typedef struct packed {
        logic        int_en;
        logic        clr_en;
        logic        out_en;
        logic        rset;
        logic        boost_power;
        logic        overrange_en;
        dcsw_range_t range_sel;
    } dcsw_chan_t;

    typedef struct packed {
        logic       comp_ext;
        logic [1:0] phase;
        logic [1:0] freq;
        logic [1:0] max_v;
    } dcsw_dcdc_t;

endpackage : dcsw_pkg

// ---- verilog/dcsw_top.sv ----
/*
 * Serial command decoder: per-channel control, main control,
 * boost converter control and software command with watchdog.
 * Assumes a 3-wire link (clock, active-low frame, data) from an
 * outside host, sampled on the 40 MHz reference clock.
 */
`timescale 1ns/1ps
`include "dcsw_params.svh"

module dcsw_top #(
    parameter int NUM_CH   = 4,
    parameter int TICK_CYC = `DCSW_WD_TICK_CYC
) (
    // Clock and reset
    input  wire logic                         ref_clk_in,
    input  wire logic                         rst_in,
    // Serial link pins
    input  wire logic                         serial_clk_in,
    input  wire logic                         frame_n_in,
    input  wire logic                         serial_in,
    // Channel and boost converter configuration
    output dcsw_pkg::dcsw_chan_t [NUM_CH-1:0] chan_cfg_out,
    output logic [NUM_CH-1:0]                 span_ext_out,
    output logic [NUM_CH-1:0]                 is_current_out,
    output dcsw_pkg::dcsw_dcdc_t              dcdc_cfg_out,
    // Status and watchdog
    output logic                              user_toggle_out,
    output logic                              wd_en_out,
    output logic [1:0]                        wd_sel_out,
    // Alert pin, open drain
    output logic                              alert_out,
    output logic                              alert_oe_n_out
);
    import dcsw_pkg::*;

    logic [2:0]                      sync1_reg;
    logic [2:0]                      sync2_reg;
    logic                            sclk_prev_reg;
    logic                            frame_prev_reg;
    dcsw_rx_t                        rx_reg;
    dcsw_rx_t                        rx_next;
    logic [`DCSW_FRAME_BITS-1:0]     shift_reg;
    logic [4:0]                      cnt_reg;
    logic [`DCSW_FRAME_BITS-1:0]     frame_reg;
    logic                            frame_ok_reg;
    logic                            soft_rst_reg;
    logic                            kick_reg;
    logic                            clr_all;
    logic                            sclk_fall;
    logic                            frame_rise;
    logic                            wr_main;
    logic                            wr_chan;
    logic [2:0]                      sel;
    logic [11:0]                     code;
    logic                            fault;

    function automatic logic range_valid(input logic [2:0] r);
        range_valid = (r <= 3'h5);
    endfunction : range_valid

    function automatic logic range_voltage(input logic [2:0] r);
        range_voltage = !r[2];
    endfunction : range_voltage

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    generate
        for (genvar i = 0; i < 3; i++) begin : g_sync
            always_ff @(posedge ref_clk_in) begin
                // Reset to idle pin levels, so no false clock edge
                if (rst_in) begin
                    sync1_reg[i] <= (i == 1);
                    sync2_reg[i] <= (i == 1);
                end else begin
                    sync1_reg[i] <= (i == 0) ? serial_clk_in :
                                    (i == 1) ? frame_n_in : serial_in;
                    sync2_reg[i] <= sync1_reg[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sclk_prev_reg  <= 1'b0;
            frame_prev_reg <= 1'b1;
        end else begin
            sclk_prev_reg  <= sync2_reg[0];
            frame_prev_reg <= sync2_reg[1];
        end
    end

    assign sclk_fall  = sclk_prev_reg && !sync2_reg[0];
    assign frame_rise = !frame_prev_reg && sync2_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // Frame receiver; data taken on serial clock falling edges
    always_comb begin
        rx_next = rx_reg;
        case (rx_reg)
            DCSW_RX_IDLE:  if (!sync2_reg[1]) rx_next = DCSW_RX_SHIFT;
            DCSW_RX_SHIFT: if (frame_rise) rx_next = DCSW_RX_DONE;
            DCSW_RX_DONE:  rx_next = DCSW_RX_IDLE;
            default:       rx_next = DCSW_RX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in)
            rx_reg <= DCSW_RX_IDLE;
        else
            rx_reg <= rx_next;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in || rx_reg == DCSW_RX_IDLE) begin
            shift_reg <= '0;
            cnt_reg   <= 5'h00;
        end else if (rx_reg == DCSW_RX_SHIFT && sclk_fall && !sync2_reg[1]) begin
            shift_reg <= {shift_reg[`DCSW_FRAME_BITS-2:0], sync2_reg[2]};
            if (cnt_reg != 5'h1f)
                cnt_reg <= cnt_reg + 5'h01;
        end
    end

    // Frames of any length but 16 are dropped whole
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            frame_ok_reg <= 1'b0;
            frame_reg    <= '0;
        end else begin
            frame_ok_reg <= (rx_reg == DCSW_RX_SHIFT) && frame_rise
                            && (cnt_reg == 5'(`DCSW_FRAME_BITS));
            if (rx_reg == DCSW_RX_SHIFT && frame_rise)
                frame_reg <= shift_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command decode
    assign sel     = frame_reg[`DCSW_SEL_HI:`DCSW_SEL_LO];
    assign code    = frame_reg[`DCSW_CODE_HI:`DCSW_CODE_LO];
    assign wr_main = frame_ok_reg && sel == `DCSW_SEL_MAIN;
    assign wr_chan = frame_ok_reg && sel == `DCSW_SEL_CHAN;
    assign clr_all = rst_in || soft_rst_reg;

    always_ff @(posedge ref_clk_in) begin
        if (clr_all) begin
            soft_rst_reg <= 1'b0;
            kick_reg     <= 1'b0;
        end else begin
            soft_rst_reg <= frame_ok_reg && sel == `DCSW_SEL_SW
                            && code == `DCSW_CODE_RESET;
            kick_reg     <= frame_ok_reg && sel == `DCSW_SEL_SW
                            && code == `DCSW_CODE_KICK;
        end
    end

    // Status toggle bit follows the user bit of every software command but the reset command, which clears it
    always_ff @(posedge ref_clk_in) begin
        if (clr_all)
            user_toggle_out <= 1'b0;
        else if (frame_ok_reg && sel == `DCSW_SEL_SW)
            user_toggle_out <= frame_reg[`DCSW_USER_BIT];
    end

    always_ff @(posedge ref_clk_in) begin
        if (clr_all) begin
            wd_en_out  <= 1'b0;
            wd_sel_out <= 2'h0;
        end else if (wr_main) begin
            wd_en_out  <= frame_reg[`DCSW_MAIN_WD_EN];
            wd_sel_out <= frame_reg[`DCSW_MAIN_WD_SEL_LO +: 2];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (clr_all) begin
            dcdc_cfg_out.comp_ext <= 1'b0;
            dcdc_cfg_out.phase    <= `DCSW_RST_DC_PHASE;
            dcdc_cfg_out.freq     <= `DCSW_RST_DC_FREQ;
            dcdc_cfg_out.max_v    <= `DCSW_RST_DC_MAXV;
        end else if (frame_ok_reg && sel == `DCSW_SEL_DCDC) begin
            dcdc_cfg_out.comp_ext <= frame_reg[`DCSW_DC_COMP];
            dcdc_cfg_out.phase    <= frame_reg[`DCSW_DC_PHASE_LO +: 2];
            dcdc_cfg_out.freq     <= frame_reg[`DCSW_DC_FREQ_LO +: 2];
            dcdc_cfg_out.max_v    <= frame_reg[`DCSW_DC_MAXV_LO +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel control
    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
            logic hit;
            logic dn_ok;
            assign hit   = wr_chan && frame_reg[`DCSW_CH_HI:`DCSW_CH_LO] == 2'(c);
            assign dn_ok = !frame_reg[`DCSW_CH_OUT_EN] && !frame_reg[`DCSW_CH_INT_EN];

            always_ff @(posedge ref_clk_in) begin
                if (clr_all) begin
                    chan_cfg_out[c] <= '{range_sel: dcsw_range_t'(`DCSW_RST_RANGE),
                                         default: 1'b0};
                end else begin
                    if (hit) begin
                        chan_cfg_out[c].int_en       <= frame_reg[`DCSW_CH_INT_EN];
                        chan_cfg_out[c].clr_en       <= frame_reg[`DCSW_CH_CLR_EN];
                        chan_cfg_out[c].out_en       <= frame_reg[`DCSW_CH_OUT_EN];
                        chan_cfg_out[c].rset         <= frame_reg[`DCSW_CH_RSET];
                        chan_cfg_out[c].overrange_en <= frame_reg[`DCSW_CH_OVERRANGE_EN];
                        // Reserved codes keep the previous range
                        if (range_valid(frame_reg[`DCSW_CH_RANGE_LO +: 3]))
                            chan_cfg_out[c].range_sel <=
                                dcsw_range_t'(frame_reg[`DCSW_CH_RANGE_LO +: 3]);
                    end
                    if (wr_main && frame_reg[`DCSW_MAIN_BOOST_ALL])
                        chan_cfg_out[c].boost_power <= 1'b1;
                    else if (hit && (frame_reg[`DCSW_CH_BOOST] || dn_ok))
                        chan_cfg_out[c].boost_power <= frame_reg[`DCSW_CH_BOOST];
                end
            end

            // Overrange only widens voltage spans; lags the config by a cycle
            // Soft reset reaches these through the config, one cycle later
            always_ff @(posedge ref_clk_in) begin
                if (rst_in) begin
                    span_ext_out[c]   <= 1'b0;
                    is_current_out[c] <= 1'b0;
                end else begin
                    span_ext_out[c]   <= chan_cfg_out[c].overrange_en
                                         && range_voltage(chan_cfg_out[c].range_sel);
                    is_current_out[c] <= !range_voltage(chan_cfg_out[c].range_sel);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog and alert pin
    dcsw_wdog #(
        .TICK_CYC (TICK_CYC)
    ) u_wdog (
        .ref_clk_in (ref_clk_in),
        .rst_in     (clr_all),
        .en_in      (wd_en_out),
        .sel_in     (wd_sel_out),
        .kick_in    (kick_reg),
        .fault_out  (fault)
    );

    // Pin only ever pulled low, never driven high
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            alert_out      <= 1'b0;
            alert_oe_n_out <= 1'b1;
        end else begin
            alert_out      <= 1'b0;
            alert_oe_n_out <= !fault;
        end
    end

endmodule : dcsw_top

// ---- verilog/dcsw_wdog.sv ----
/*
 * Watchdog timer of the serial command decoder.
 * Assumes kick and clear are one-cycle pulses on the same clock.
 */
`timescale 1ns/1ps
`include "dcsw_params.svh"

module dcsw_wdog #(
    parameter int TICK_CYC = `DCSW_WD_TICK_CYC
) (
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       rst_in,
    // Control
    input  wire logic       en_in,
    input  wire logic [1:0] sel_in,
    input  wire logic       kick_in,
    // Status
    output logic            fault_out
);
    import dcsw_pkg::*;

    localparam int TW = $clog2(TICK_CYC + 1);

    logic [TW-1:0] tick_reg;
    logic [15:0]   ms_reg;
    logic [15:0]   limit;

    function automatic logic [15:0] wd_limit(input logic [1:0] sel);
        case (sel)
            2'h0:    wd_limit = `DCSW_WD_MS_0;
            2'h1:    wd_limit = `DCSW_WD_MS_1;
            2'h2:    wd_limit = `DCSW_WD_MS_2;
            default: wd_limit = `DCSW_WD_MS_3;
        endcase
    endfunction : wd_limit

    assign limit = wd_limit(sel_in);

    ////////////////////////////////////////////////////////////////////////////
    // Counting; disabled watchdog holds everything idle
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !en_in || kick_in) begin
            tick_reg <= '0;
            ms_reg   <= 16'h0000;
        end else if (tick_reg == TW'(TICK_CYC - 1)) begin
            tick_reg <= '0;
            if (ms_reg != limit)
                ms_reg <= ms_reg + 16'h0001;
        end else begin
            tick_reg <= tick_reg + TW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault stays until a keep-alive, a disable or a reset
    // A keep-alive in the very timeout cycle loses: the miss is not hidden
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !en_in)
            fault_out <= 1'b0;
        else if (ms_reg >= limit && !fault_out)
            fault_out <= 1'b1;
        else if (kick_in)
            fault_out <= 1'b0;
    end

endmodule : dcsw_wdog
